/* File: rtl/block_transfer_unit.v */
// One block transfer unit: trigger edge detection, range checks, request.
// Assumes the engine answers each request with a one-cycle done pulse.
`timescale 1ns/1ns
`default_nettype none
`include "marker_block_transfer_regs.vh"

module block_transfer_unit (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Unit inputs
   input wire enable,
   input wire eval_enable,
   input wire trigger,
   input wire fill_mode,
   input wire [31:0] source_offset,
   input wire [31:0] dest_offset,
   input wire [31:0] byte_count,
   // Engine side
   input wire done,
   output reg request,
   // Error outputs
   output wire count_overflow_error,
   output wire overlap_error_legacy,
   output wire range_error
);
   reg trigger_q;
   wire active;
   wire any_error;
   wire [32:0] src_end;
   wire [32:0] dst_end;

   // Option clear means always enabled
   assign active = enable | ~eval_enable;
   // Fill reads only one source byte
   assign src_end = {1'b0, source_offset} + (fill_mode ? 33'h0_0000_0001 : {1'b0, byte_count});
   assign dst_end = {1'b0, dest_offset} + {1'b0, byte_count};

   // Checks run every cycle, not only at edges
   assign range_error = ({1'b0, source_offset} >= `MEM_BYTES) |
      ({1'b0, dest_offset} >= `MEM_BYTES) | (byte_count == 32'h0000_0000);
   assign count_overflow_error = (byte_count > `MAX_COUNT) |
      (src_end > `MEM_BYTES) | (dst_end > `MEM_BYTES);
   // Overlap is legal, output kept only for compatibility
   assign overlap_error_legacy = 1'b0;
   assign any_error = range_error | count_overflow_error;

   // Edge detect; held level or edges while pending do nothing
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trigger_q <= 1'b0;
         request <= 1'b0;
      end else begin
         trigger_q <= trigger;
         if (done)
            request <= 1'b0;
         else if (trigger & ~trigger_q & active & ~any_error & ~request)
            request <= 1'b1;
      end
   end
endmodule // block_transfer_unit

`default_nettype wire

/* File: rtl/marker_block_transfer.v */
// Marker block transfer engine: 384-byte marker memory, 32 transfer units,
// one shared byte mover, Avalon-MM slave with waitrequest, one irq line.
// Assumes a single clock and a master that holds requests until accepted.
// Memory accesses stall while a transfer runs, one cycle per moved byte.
`timescale 1ns/1ns
`default_nettype none
`include "marker_block_transfer_regs.vh"

module marker_block_transfer (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Avalon-MM slave, byte address
   input wire [11:0] address,
   input wire read,
   input wire write,
   input wire [3:0] byteenable,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   // Interrupt
   output wire irq,
   // Per-unit error outputs
   output wire [31:0] count_overflow_error,
   output wire [31:0] overlap_error_legacy,
   output wire [31:0] range_error
);
   localparam ST_IDLE = 1'b0;
   localparam ST_MOVE = 1'b1;

   // Marker memory, byte zero is the first marker byte
   reg [7:0] mem [0:`MEM_DEPTH-1];
   // Unit input registers
   reg [31:0] ctl_enable;
   reg [31:0] ctl_eval;
   reg [31:0] ctl_fill;
   reg [31:0] ctl_trigger;
   reg [31:0] src_off [0:31];
   reg [31:0] dst_off [0:31];
   reg [31:0] cnt [0:31];
   // Interrupt registers
   reg [31:0] irq_status;
   reg [31:0] irq_mask;
   // Bus answer
   reg ack;
   // Engine state
   reg state;
   reg [4:0] eng_unit;
   reg [8:0] eng_src;
   reg [8:0] eng_dst;
   reg [10:0] eng_left;
   reg eng_desc;
   reg eng_fill;
   reg [7:0] fill_byte;
   reg [31:0] done_vec;

   wire [31:0] request;
   wire req_any;
   wire bus_req;
   wire mem_hit;
   wire unit_hit;
   wire [4:0] bus_unit;
   wire [8:0] mem_idx;
   wire bus_stall;
   wire bus_mem_busy;
   wire take;
   wire [31:0] wr_bits;
   // Decoded strobes, read-back views and per-step values of the mover
   wire [31:0] req_live;
   wire start_ok;
   wire walk_down;
   wire mem_wr;
   wire status_wr;
   wire [31:0] ctrl_view;
   wire [31:0] eng_view;
   wire [7:0] move_byte;
   wire [8:0] next_src;
   wire [8:0] next_dst;
   wire [10:0] next_left;
   integer i;

   // Arbiter choice and its parameters
   reg [4:0] pick;
   reg [31:0] p_src;
   reg [31:0] p_dst;
   reg [31:0] p_cnt;
   reg p_err;
   reg [8:0] p_src_last;
   reg [8:0] p_dst_last;

   // One unit per index, all sharing the mover
   genvar g;
   generate
      for (g = 0; g < `NUM_UNITS; g = g + 1) begin : unit
         block_transfer_unit u_unit (
            .clk(clk),
            .sys_rst(sys_rst),
            .enable(ctl_enable[g]),
            .eval_enable(ctl_eval[g]),
            .trigger(ctl_trigger[g]),
            .fill_mode(ctl_fill[g]),
            .source_offset(src_off[g]),
            .dest_offset(dst_off[g]),
            .byte_count(cnt[g]),
            .done(done_vec[g]),
            .request(request[g]),
            .count_overflow_error(count_overflow_error[g]),
            .overlap_error_legacy(overlap_error_legacy[g]),
            .range_error(range_error[g])
         );
      end
   endgenerate

   // Address decode
   assign bus_req = read | write;
   assign mem_idx = address[10:2];
   assign mem_hit = (address[11] == 1'b0) && (mem_idx < 9'd384);
   assign unit_hit = (address[11:10] == 2'b10) && (address[9] == 1'b0);
   assign bus_unit = address[8:4];

   // A unit whose done pulse is out still shows its request for one more
   // cycle; masking it keeps the mover from running that unit twice
   assign req_live = request & ~done_vec;
   assign req_any = |req_live;

   // Memory access waits while the mover owns the memory
   assign bus_mem_busy = mem_hit & (state != ST_IDLE);
   assign bus_stall = bus_req & bus_mem_busy;
   assign waitrequest = bus_req & ~ack;
   assign take = ack & bus_req;
   assign irq = |(irq_status & irq_mask);

   // Write strobes, all at the edge that accepts the access
   assign mem_wr = take & write & mem_hit & byteenable[0];
   assign status_wr = take & write & (address == `IRQ_STATUS);

   // Byte lane merge for 32-bit registers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      begin
         merge = {be[3] ? nw[31:24] : old[31:24],
            be[2] ? nw[23:16] : old[23:16],
            be[1] ? nw[15:8] : old[15:8],
            be[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   assign wr_bits = merge(32'h0000_0000, writedata, byteenable);

   // Lowest requesting unit wins; fixed priority is simple and each
   // transfer is short, so starvation stays bounded by other units' work
   always @* begin
      pick = 5'd0;
      for (i = `NUM_UNITS - 1; i >= 0; i = i - 1) begin
         if (req_live[i])
            pick = i[4:0];
      end
      p_src = src_off[pick];
      p_dst = dst_off[pick];
      p_cnt = cnt[pick];
      p_err = count_overflow_error[pick] | range_error[pick];
      p_src_last = p_src[8:0] + p_cnt[8:0] - 9'd1;
      p_dst_last = p_dst[8:0] + p_cnt[8:0] - 9'd1;
   end

   // The mover starts only while the bus leaves the memory alone
   assign start_ok = req_any & ~(bus_req & mem_hit);
   // Copy with the destination above the source walks from the top end,
   // so every overlapped source byte is read before it is overwritten
   assign walk_down = ~ctl_fill[pick] & (p_dst[8:0] > p_src[8:0]);

   // Per-step values of the mover; a fill never reads memory after start,
   // since its source byte was latched when the transfer began
   assign move_byte = eng_fill ? fill_byte : mem[eng_src];
   assign next_src = eng_desc ? eng_src - 9'd1 : eng_src + 9'd1;
   assign next_dst = eng_desc ? eng_dst - 9'd1 : eng_dst + 9'd1;
   assign next_left = eng_left - 11'd1;

   // Control word as software reads it back; busy is the pending flag,
   // errors are the live checks, not a copy taken at the last trigger
   assign ctrl_view = {21'h00_0000,
      range_error[bus_unit],
      overlap_error_legacy[bus_unit],
      count_overflow_error[bus_unit],
      3'b000,
      request[bus_unit],
      ctl_trigger[bus_unit],
      ctl_fill[bus_unit],
      ctl_eval[bus_unit],
      ctl_enable[bus_unit]};
   // Engine status: current unit and whether bytes are moving
   assign eng_view = {26'h000_0000, eng_unit, state};

   // Bus answer one cycle after the request, later if memory is busy
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack <= 1'b0;
         readdata <= `RST_WORD;
      end else begin
         ack <= bus_req & ~ack & ~bus_stall;
         if (read & ~ack & ~bus_stall) begin
            readdata <= `RST_WORD; // Unmapped reads return zero
            if (mem_hit)
               readdata <= {24'h00_0000, mem[mem_idx]};
            else if (unit_hit) begin
               case (address[3:2])
                  `UNIT_CTRL: readdata <= ctrl_view;
                  `UNIT_SRC: readdata <= src_off[bus_unit];
                  `UNIT_DST: readdata <= dst_off[bus_unit];
                  default: readdata <= cnt[bus_unit];
               endcase
            end else if (address == `IRQ_STATUS)
               readdata <= irq_status;
            else if (address == `IRQ_MASK)
               readdata <= irq_mask;
            else if (address == `ENGINE_STATUS)
               readdata <= eng_view;
         end
      end
   end

   // Unit input registers, written at the accepting edge
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_enable <= `RST_WORD;
         ctl_eval <= `RST_WORD;
         ctl_fill <= `RST_WORD;
         ctl_trigger <= `RST_WORD;
         irq_mask <= `RST_WORD;
         for (i = 0; i < `NUM_UNITS; i = i + 1) begin
            src_off[i] <= `RST_WORD;
            dst_off[i] <= `RST_WORD;
            cnt[i] <= `RST_WORD;
         end
      end else if (take & write) begin
         if (unit_hit) begin
            case (address[3:2])
               `UNIT_CTRL: begin
                  if (byteenable[0]) begin
                     ctl_enable[bus_unit] <= writedata[`CTRL_ENABLE];
                     ctl_eval[bus_unit] <= writedata[`CTRL_EVAL];
                     ctl_fill[bus_unit] <= writedata[`CTRL_FILL];
                     ctl_trigger[bus_unit] <= writedata[`CTRL_TRIGGER];
                  end
               end
               `UNIT_SRC: src_off[bus_unit] <= merge(src_off[bus_unit], writedata, byteenable);
               `UNIT_DST: dst_off[bus_unit] <= merge(dst_off[bus_unit], writedata, byteenable);
               default: cnt[bus_unit] <= merge(cnt[bus_unit], writedata, byteenable);
            endcase
         end else if (address == `IRQ_MASK)
            irq_mask <= merge(irq_mask, writedata, byteenable);
      end
   end

   // Completion status; a new completion beats a clear in the same cycle
   // A clear touches only the bits written as one
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         irq_status <= `RST_WORD;
      else if (status_wr)
         irq_status <= (irq_status & ~wr_bits) | done_vec;
      else
         irq_status <= irq_status | done_vec;
   end

   // Byte mover; one byte per cycle, the memory's only writer
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         eng_unit <= 5'd0;
         eng_src <= 9'd0;
         eng_dst <= 9'd0;
         eng_left <= 11'd0;
         eng_desc <= 1'b0;
         eng_fill <= 1'b0;
         fill_byte <= `RST_BYTE;
         done_vec <= `RST_WORD;
         for (i = 0; i < `MEM_DEPTH; i = i + 1)
            mem[i] <= `RST_BYTE;
      end else begin
         done_vec <= `RST_WORD;
         case (state)
            ST_IDLE: begin
               if (mem_wr)
                  mem[mem_idx] <= writedata[7:0];
               else if (start_ok) begin
                  eng_unit <= pick;
                  if (p_err)
                     // Parameters changed into error after the edge: no move
                     done_vec[pick] <= 1'b1;
                  else begin
                     state <= ST_MOVE;
                     eng_fill <= ctl_fill[pick];
                     // Latched so a destination covering the source keeps it
                     fill_byte <= mem[p_src[8:0]];
                     eng_left <= p_cnt[10:0];
                     // Destination above source in copy: walk from the top
                     if (walk_down) begin
                        eng_desc <= 1'b1;
                        eng_src <= p_src_last;
                        eng_dst <= p_dst_last;
                     end else begin
                        eng_desc <= 1'b0;
                        eng_src <= p_src[8:0];
                        eng_dst <= p_dst[8:0];
                     end
                  end
               end
            end
            ST_MOVE: begin
               // Single byte per step regardless of operand type
               mem[eng_dst] <= move_byte;
               eng_dst <= next_dst;
               eng_src <= next_src;
               eng_left <= next_left;
               if (eng_left == 11'd1) begin
                  state <= ST_IDLE;
                  done_vec[eng_unit] <= 1'b1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // marker_block_transfer

`default_nettype wire

/* File: rtl/marker_block_transfer_regs.vh */
// Constants for the marker block transfer engine: register map, fields,
// reset values and sizes. Included by every design file of the block.
`ifndef MARKER_BLOCK_TRANSFER_REGS_VH
`define MARKER_BLOCK_TRANSFER_REGS_VH

// Sizes
`define NUM_UNITS 32
`define MEM_BYTES 33'h0_0000_0180
`define MEM_DEPTH 384
`define MAX_COUNT 32'h0000_0400

// Byte address map (12-bit byte address, one word per register)
`define MEM_BASE 12'h000
`define UNIT_BASE 12'h800
`define IRQ_STATUS 12'hC00
`define IRQ_MASK 12'hC04
`define ENGINE_STATUS 12'hC08

// Word index inside a unit window (address bits 3:2)
`define UNIT_CTRL 2'h0
`define UNIT_SRC 2'h1
`define UNIT_DST 2'h2
`define UNIT_COUNT 2'h3

// Unit control register fields
`define CTRL_ENABLE 0
`define CTRL_EVAL 1
`define CTRL_FILL 2
`define CTRL_TRIGGER 3
`define CTRL_BUSY 4
`define CTRL_ERR_OVF 8
`define CTRL_ERR_LEGACY 9
`define CTRL_ERR_RANGE 10

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00

`endif

/* File: verif/host_bus.sv */
// Controller program logic: sets up the units over the register bus.
// Assumes the top bench is tb and owns the closing report.
`timescale 1ns/1ns
`default_nettype none
module host_bus (
   // Clock
   input wire clk,
   // Bus towards the engine
   output logic [11:0] address,
   output logic read,
   output logic write,
   output logic [3:0] byteenable,
   output logic [31:0] writedata,
   input wire [31:0] readdata,
   input wire waitrequest
);
   // Idle bus at time zero
   initial begin
      address = 12'h000;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'hf;
      writedata = 32'h0000_0000;
   end
   // One access; the request stands until waitrequest is seen low
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 1500);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 1500) begin
         tb.err_total++;
         tb.summarize();
      end
      @(negedge clk); // Outputs settle before the caller looks
   endtask
endmodule // host_bus
`default_nettype wire

/* File: verif/mbt_checker_assertions.sv */
// Port checker for the marker block transfer engine.
// Assumes one clock and a bus master that drops each request after its answer.
`timescale 1ns/1ns
`default_nettype none
module mbt_checker (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Register bus
   input wire read,
   input wire write,
   input wire [31:0] readdata,
   input wire waitrequest,
   // Interrupt and unit errors
   input wire irq,
   input wire [31:0] count_overflow_error,
   input wire [31:0] overlap_error_legacy,
   input wire [31:0] range_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   reg [10:0] wcnt;
   // Stall length; a transfer may hold memory accesses for a whole count
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) wcnt <= 11'h000;
      else wcnt <= waitrequest ? wcnt + 11'h001 : 11'h000;
   end
   a_legacy_low: assert property (overlap_error_legacy == 32'h0000_0000)
      else $error("legacy overlap error active");
   a_first_wait: assert property ($rose(read | write) |-> waitrequest)
      else $error("request answered without a wait cycle");
   a_ack_after_wait: assert property ((read | write) && !waitrequest |-> $past(waitrequest))
      else $error("answer not preceded by a wait cycle");
   a_wait_bound: assert property (wcnt < 11'h44c)
      else $error("bus stalled too long");
   a_reset_errs: assert property ($fell(sys_rst) |->
      range_error == 32'hffff_ffff && count_overflow_error == 32'h0000_0000)
      else $error("error outputs wrong after reset");
   a_err_by_write: assert property ($changed({range_error, count_overflow_error}) |->
      $past(write && !waitrequest))
      else $error("error outputs moved without a write");
   a_irq_fall: assert property ($fell(irq) |-> $past(write && !waitrequest))
      else $error("irq dropped without a write");
   a_rdata_hold: assert property ($changed(readdata) |-> read && !waitrequest)
      else $error("read data moved outside a read");
   c_irq: cover property ($rose(irq));
   c_ovf: cover property (count_overflow_error != 32'h0000_0000);
   c_stall: cover property (wcnt > 11'h010);
endmodule // mbt_checker

bind marker_block_transfer mbt_checker mbt_checker_inst (.clk(clk), .sys_rst(sys_rst),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
   .count_overflow_error(count_overflow_error), .overlap_error_legacy(overlap_error_legacy),
   .range_error(range_error));
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the marker block transfer engine.
// Assumes host_bus as the controller and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   wire [11:0] address;
   wire read;
   wire write;
   wire [3:0] byteenable;
   wire [31:0] writedata;
   wire [31:0] readdata;
   wire waitrequest;
   wire irq;
   wire [31:0] ovf;
   wire [31:0] legacy;
   wire [31:0] rng;
   int err_total = 0;
   int n_compared = 0;
   logic [7:0] mem [0:383];
   logic [31:0] e_rng = 32'hffff_ffff;
   logic [31:0] e_ovf = 32'h0000_0000;
   logic [31:0] q;
   initial forever #50 clk = ~clk;
   marker_block_transfer marker_block_transfer_inst (.clk(clk), .sys_rst(sys_rst),
      .address(address), .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
      .count_overflow_error(ovf), .overlap_error_legacy(legacy), .range_error(rng));
   host_bus host_bus_inst (.clk(clk), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest));
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host_bus_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a);
      host_bus_inst.xfer(1'b0, a, 32'h0000_0000, q);
   endtask
   // Whole memory against the reference copy
   task automatic mem_check();
      for (int k = 0; k < 384; k++) begin
         rd(12'(4 * k));
         chk("mem", {24'h00_0000, mem[k]}, q);
      end
   endtask
   // Expected {overflow, range}; fill reads only one source byte
   function automatic logic [1:0] errs(input logic f, input logic [31:0] s, d, c);
      logic r;
      logic o;
      r = s >= 384 || d >= 384 || c == 0;
      o = c > 1024 || {1'b0, s} + (f ? 33'h1 : {1'b0, c}) > 384 || {1'b0, d} + {1'b0, c} > 384;
      return {o, r};
   endfunction
   task automatic run(input int u, input logic [3:0] ctl, input logic [31:0] s, d, c);
      logic [11:0] b;
      logic [1:0] e;
      logic go;
      logic [7:0] t [0:1023];
      int n;
      b = 12'h800 + 12'(16 * u);
      e = errs(ctl[2], s, d, c);
      go = (ctl[0] | ~ctl[1]) && e == 2'b00;
      wr(b, {28'h000_0000, ctl});
      wr(b + 12'h004, s);
      wr(b + 12'h008, d);
      wr(b + 12'h00c, c);
      rd(b + 12'h004);
      chk("source_offset", s, q);
      rd(b + 12'h008);
      chk("dest_offset", d, q);
      rd(b + 12'h00c);
      chk("byte_count", c, q);
      e_rng[u] = e[0];
      e_ovf[u] = e[1];
      chk("range_error", e_rng, rng);
      chk("count_overflow_error", e_ovf, ovf);
      wr(b, {28'h000_0000, ctl | 4'h8});
      for (n = 0; n < (go ? 1200 : 30) && irq !== go; n++) @(posedge clk);
      chk("irq", {31'h0, go}, {31'h0, irq});
      if (irq !== go) summarize();
      rd(b);
      chk("ctrl", {21'h00_0000, e[0], 1'b0, e[1], 4'h0, ctl | 4'h8}, q);
      if (go) begin
         rd(12'hc08);
         chk("engine status", 32'(u) << 1, q);
      end
      // Reference move through a copy, so overlap cannot corrupt it
      if (go && e == 2'b00) begin
         for (n = 0; n < c; n++) t[n] = mem[ctl[2] ? s : s + n];
         for (n = 0; n < c; n++) mem[d + n] = t[n];
      end
      if (u == 0) begin
         wr(12'hc04, 32'h0000_0000);
         chk("irq masked", 32'h0000_0000, {31'h0, irq});
         wr(12'hc04, 32'hffff_ffff);
      end
      wr(12'hc00, 32'h1 << u);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      wr(b, {28'h000_0000, ctl | 4'h8});
      repeat (30) @(posedge clk);
      chk("irq held", 32'h0000_0000, {31'h0, irq});
      mem_check();
   endtask
   initial begin
      void'($urandom(32'h724a_1ddb));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk("range_error", e_rng, rng);
      chk("legacy", 32'h0000_0000, legacy);
      rd(12'h850);
      chk("ctrl", 32'h0000_0400, q);
      rd(12'h700);
      chk("unmapped", 32'h0000_0000, q);
      rd(12'hc08);
      chk("engine status", 32'h0000_0000, q);
      wr(12'hc04, 32'hffff_ffff);
      for (int k = 0; k < 384; k++) begin
         mem[k] = 8'($urandom);
         wr(12'(4 * k), {24'h00_0000, mem[k]});
      end
      run(0, 4'h1, 10, 12, 50);
      run(1, 4'h1, 40, 30, 100);
      run(2, 4'h5, 5, 200, 184);
      run(3, 4'h3, 0, (96 - 1) * 4, 4);
      run(4, 4'h1, (20 - 1) * 2, (30 - 1) * 2, 2);
      run(5, 4'h1, 380, 0, 5);
      run(6, 4'h1, 384, 0, 1);
      run(7, 4'h1, 0, 0, 0);
      run(8, 4'h2, 0, 100, 8);
      run(9, 4'h0, 100, 0, 8);
      run(31, 4'h5, 0, 0, 1025);
      repeat (10) run($urandom % 32, 4'($urandom) & 4'h7, $urandom % 384, $urandom % 384,
                      1 + $urandom % 400);
      summarize();
   end
endmodule // tb
`default_nettype wire
